// ===== rtl/line_ctrl_defines.vh
`ifndef LINE_CTRL_DEFINES_VH
`define LINE_CTRL_DEFINES_VH

// system clock rate in MHz
`define SYS_CLK_MHZ 200
// least width of the combined loop select pulse that counts as a reset, in ns
`define RST_MIN_NS 1000
// least reset pulse in system clock cycles, rounded up
`define RST_MIN_CYC ((`RST_MIN_NS * `SYS_CLK_MHZ + 999) / 1000)
// width of the reset pulse counter
`define RST_CNT_W 8
// bit periods of low amplitude before receive loss is shown
`define RX_LOS_BITS 32
// transmit clock cycles without a line mark before transmit loss is shown
`define TX_LOS_CYC 32
// width of both loss counters
`define LOS_CNT_W 6

// line length code that selects the 2048 kbit/s mode
`define LEN_CEPT 3'h0
// line length code after power-on
`define LEN_RST 3'h0
// t1 mode flag after power-on (cept)
`define T1_RST 1'h0

// bit positions in the synchronised pin vector
`define PIN_RX_CLK 0
`define PIN_TX_CLK 1
`define PIN_RX_A 2
`define PIN_RX_B 3
`define PIN_TEST_P 4
`define PIN_TEST_N 5
`define PIN_TXD_P 6
`define PIN_TXD_N 7
`define PIN_LOCAL 8
`define PIN_REMOTE 9
`define PIN_LEN0 10
`define PIN_LEN1 11
`define PIN_LEN2 12
`define PIN_SEL_N 13
`define PIN_RX_LOW 14
`define PIN_SENSE_A 15
`define PIN_SENSE_B 16
`define PIN_MODE 17
`define PIN_COUNT 18

`endif

// ===== rtl/word_buffer2.v
`timescale 1ns/100ps
// two-entry buffer with valid and ready on both sides
module word_buffer2 #(
    parameter WIDTH = 2
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // filling side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // draining side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);

    reg [WIDTH-1:0] mem0; // entry at the head
    reg [WIDTH-1:0] mem1; // entry behind the head
    reg [1:0] count; // number of words held

    wire push; // word taken in
    wire pop; // word handed out

    assign in_ready_o = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign out_data_o = mem0;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // storage and fill count; head shifts forward on a pop
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem0 <= {WIDTH{1'b0}};
            mem1 <= {WIDTH{1'b0}};
            count <= 2'h0;
        end else begin
            case ({push, pop})
                2'b10: begin
                    // push only
                    if (count == 2'h0) begin
                        mem0 <= in_data_i;
                    end else begin
                        mem1 <= in_data_i;
                    end
                    count <= count + 2'h1;
                end
                2'b01: begin
                    // pop only
                    mem0 <= mem1;
                    count <= count - 2'h1;
                end
                2'b11: begin
                    // both: new word goes where the head will be
                    if (count == 2'h1) begin
                        mem0 <= in_data_i;
                    end else begin
                        mem0 <= mem1;
                        mem1 <= in_data_i;
                    end
                end
                default: begin
                    // idle
                    count <= count;
                end
            endcase
        end
    end

endmodule

// ===== rtl/line_interface_ctrl.v
// Behaviour
// - local loop cuts receiver off line inputs
// - local loop feeds receiver from test inputs
// - local loop keeps transmit data on line
// - local loop selected by high local select
// - remote loop sends recovered data to transmitter
// - remote loop keeps receive outputs and clock
// - remote loop ignores transmit data inputs
// - remote loop selected by high remote select
// - five control inputs qualified by select line
// - controls captured on select rising edge
// - low amplitude 32 bits forces rails high
// - mode high drives receive loss high
// - mode low shows transmit loss after 32
// - power-on leaves device in cept mode
// - reset starts on falling edge of pulse
// - code zero cept, nonzero t1 with length
// - dual-rail data lines are active low
// - mode low puts losses on oscillator pins
`timescale 1ns/100ps
`include "line_ctrl_defines.vh"
module line_interface_ctrl (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // link clocks, sampled
    input wire rx_clk_i,
    input wire tx_clk_i,
    // line receive marks and receive level comparator
    input wire rx_line_a_i,
    input wire rx_line_b_i,
    input wire rx_level_low_i,
    // loopback test inputs, active low
    input wire test_in_pos_i,
    input wire test_in_neg_i,
    // transmit dual-rail data, active low
    input wire tx_data_pos_n_i,
    input wire tx_data_neg_n_i,
    // transmit driver sense
    input wire tx_sense_a_i,
    input wire tx_sense_b_i,
    // control port
    input wire local_loop_sel_i,
    input wire remote_loop_sel_i,
    input wire line_len_sel0_i,
    input wire line_len_sel1_i,
    input wire line_len_sel2_i,
    input wire ctrl_latch_sel_n_i,
    input wire mode_i,
    // receive dual-rail side toward the framer
    output reg rx_data_pos_n_o,
    output reg rx_data_neg_n_o,
    output reg recovered_clk_o,
    output wire rx_valid_o,
    input wire rx_ready_i,
    // line transmit marks
    output reg tx_line_a_o,
    output reg tx_line_b_o,
    // loss indications on the oscillator pins
    output wire rx_sig_loss_n_o,
    output wire tx_sig_loss_n_o,
    // configuration state
    output reg t1_mode_o,
    output reg [2:0] line_len_o,
    output wire local_loop_o,
    output wire remote_loop_o,
    output reg reset_done_o
);

    // synchroniser stages for every pin from outside except the framer ready
    wire [`PIN_COUNT-1:0] pins_raw; // raw pin vector
    reg [`PIN_COUNT-1:0] pins_meta; // first stage, read only by the second
    reg [`PIN_COUNT-1:0] pins_sync; // second stage
    reg [`PIN_COUNT-1:0] pins_last; // previous synchronised value

    assign pins_raw[`PIN_RX_CLK] = rx_clk_i;
    assign pins_raw[`PIN_TX_CLK] = tx_clk_i;
    assign pins_raw[`PIN_RX_A] = rx_line_a_i;
    assign pins_raw[`PIN_RX_B] = rx_line_b_i;
    assign pins_raw[`PIN_TEST_P] = test_in_pos_i;
    assign pins_raw[`PIN_TEST_N] = test_in_neg_i;
    assign pins_raw[`PIN_TXD_P] = tx_data_pos_n_i;
    assign pins_raw[`PIN_TXD_N] = tx_data_neg_n_i;
    assign pins_raw[`PIN_LOCAL] = local_loop_sel_i;
    assign pins_raw[`PIN_REMOTE] = remote_loop_sel_i;
    assign pins_raw[`PIN_LEN0] = line_len_sel0_i;
    assign pins_raw[`PIN_LEN1] = line_len_sel1_i;
    assign pins_raw[`PIN_LEN2] = line_len_sel2_i;
    assign pins_raw[`PIN_SEL_N] = ctrl_latch_sel_n_i;
    assign pins_raw[`PIN_RX_LOW] = rx_level_low_i;
    assign pins_raw[`PIN_SENSE_A] = tx_sense_a_i;
    assign pins_raw[`PIN_SENSE_B] = tx_sense_b_i;
    assign pins_raw[`PIN_MODE] = mode_i;

    // two flip-flops per pin, then a history stage for edge finding
    genvar gi;
    generate
        for (gi = 0; gi < `PIN_COUNT; gi = gi + 1) begin : g_sync
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    pins_meta[gi] <= 1'b0;
                    pins_sync[gi] <= 1'b0;
                    pins_last[gi] <= 1'b0;
                end else begin
                    pins_meta[gi] <= pins_raw[gi];
                    pins_sync[gi] <= pins_meta[gi];
                    pins_last[gi] <= pins_sync[gi];
                end
            end
        end
    endgenerate

    // link clock edges seen on the system clock
    wire rx_edge; // rising edge of the recovered clock
    wire tx_edge; // rising edge of the transmit clock
    assign rx_edge = pins_sync[`PIN_RX_CLK] && !pins_last[`PIN_RX_CLK];
    assign tx_edge = pins_sync[`PIN_TX_CLK] && !pins_last[`PIN_TX_CLK];

    // ------------------------------------------------------------ control port
    wire sel_n; // synchronised select, active low
    wire sel_rise; // select returning high
    reg [4:0] ctrl_held; // latched {len2,len1,len0,remote,local}
    wire [4:0] ctrl_live; // pins as they stand
    wire [4:0] ctrl_eff; // control in force

    assign sel_n = pins_sync[`PIN_SEL_N];
    assign sel_rise = sel_n && !pins_last[`PIN_SEL_N];
    assign ctrl_live = {pins_sync[`PIN_LEN2], pins_sync[`PIN_LEN1], pins_sync[`PIN_LEN0],
                        pins_sync[`PIN_REMOTE], pins_sync[`PIN_LOCAL]};

    // latch the levels standing just before select rose
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_held <= 5'h00;
        end else if (sel_rise) begin
            ctrl_held <= {pins_last[`PIN_LEN2], pins_last[`PIN_LEN1], pins_last[`PIN_LEN0],
                          pins_last[`PIN_REMOTE], pins_last[`PIN_LOCAL]};
        end
    end

    // select low is transparent; select high holds the latched copy
    assign ctrl_eff = sel_n ? ctrl_held : ctrl_live;

    wire loc_req; // local select in force
    wire rem_req; // remote select in force
    wire both_req; // both selects high: reset request
    assign loc_req = ctrl_eff[0];
    assign rem_req = ctrl_eff[1];
    assign both_req = loc_req && rem_req;
    // a reset request is no loopback request
    assign local_loop_o = loc_req && !both_req;
    assign remote_loop_o = rem_req && !both_req;

    // ------------------------------------------------------------ reset pulse
    reg [`RST_CNT_W-1:0] rst_cnt; // cycles of the combined high pulse
    reg both_last; // combined request one cycle ago
    reg [2:0] len_at_pulse; // length code standing with the pulse
    wire pulse_fall; // combined pulse ended
    wire pulse_long; // pulse reached the least width
    localparam integer RST_MIN_FULL = `RST_MIN_CYC; // least pulse width, full integer
    localparam [`RST_CNT_W-1:0] RST_MIN = RST_MIN_FULL[`RST_CNT_W-1:0]; // cut to counter width

    assign pulse_fall = both_last && !both_req;
    assign pulse_long = (rst_cnt >= RST_MIN);

    // measure the pulse, saturating at the least width
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_cnt <= {`RST_CNT_W{1'b0}};
            both_last <= 1'b0;
            len_at_pulse <= `LEN_RST;
        end else begin
            both_last <= both_req;
            if (both_req) begin
                len_at_pulse <= ctrl_eff[4:2];
                if (!pulse_long) begin
                    rst_cnt <= rst_cnt + {{(`RST_CNT_W-1){1'b0}}, 1'b1};
                end
            end else begin
                rst_cnt <= {`RST_CNT_W{1'b0}};
            end
        end
    end

    // operating mode: cept after power-on, reloaded by a valid reset
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            t1_mode_o <= `T1_RST;
            line_len_o <= `LEN_RST;
            reset_done_o <= 1'b0;
        end else begin
            reset_done_o <= 1'b0;
            // short pulses fall through without effect
            if (pulse_fall && pulse_long) begin
                t1_mode_o <= (len_at_pulse != `LEN_CEPT);
                line_len_o <= len_at_pulse;
                reset_done_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------ receive path
    reg rx_mark_a; // receiver input mark, positive rail
    reg rx_mark_b; // receiver input mark, negative rail
    wire src_a; // receiver source, positive
    wire src_b; // receiver source, negative

    // local loop swaps the line for the active low test inputs
    assign src_a = local_loop_o ? !pins_sync[`PIN_TEST_P] : pins_sync[`PIN_RX_A];
    assign src_b = local_loop_o ? !pins_sync[`PIN_TEST_N] : pins_sync[`PIN_RX_B];

    // sample a bit on every recovered clock edge, stalled while the buffer is full
    reg samp_valid; // sampled word waiting for the buffer
    wire buf_in_ready; // buffer has room
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_mark_a <= 1'b0;
            rx_mark_b <= 1'b0;
            samp_valid <= 1'b0;
        end else if (rx_edge && (!samp_valid || buf_in_ready)) begin
            rx_mark_a <= src_a;
            rx_mark_b <= src_b;
            samp_valid <= 1'b1;
        end else if (buf_in_ready) begin
            samp_valid <= 1'b0;
        end
    end

    // receive loss: count bit periods with low amplitude
    reg [`LOS_CNT_W-1:0] rx_los_cnt; // bit periods below threshold
    reg rx_loss; // receive loss in force
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_los_cnt <= {`LOS_CNT_W{1'b0}};
            rx_loss <= 1'b0;
        end else if (!pins_sync[`PIN_RX_LOW]) begin
            rx_los_cnt <= {`LOS_CNT_W{1'b0}};
            rx_loss <= 1'b0;
        end else if (rx_edge && !rx_loss) begin
            rx_los_cnt <= rx_los_cnt + {{(`LOS_CNT_W-1){1'b0}}, 1'b1};
            if (rx_los_cnt == (`RX_LOS_BITS - 1)) begin
                rx_loss <= 1'b1;
            end
        end
    end

    // two-entry buffer toward the framer
    wire [1:0] buf_data; // {neg, pos} marks
    wire buf_valid; // word waiting for the framer
    word_buffer2 #(
        .WIDTH(2)
    ) u_rx_buf (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(samp_valid),
        .in_ready_o(buf_in_ready),
        .in_data_i({rx_mark_b, rx_mark_a}),
        .out_valid_o(buf_valid),
        .out_ready_i(rx_ready_i),
        .out_data_o(buf_data)
    );
    assign rx_valid_o = buf_valid;

    // output rails and clock, same in normal mode and remote loop
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_data_pos_n_o <= 1'b1;
            rx_data_neg_n_o <= 1'b1;
            recovered_clk_o <= 1'b0;
        end else begin
            recovered_clk_o <= pins_sync[`PIN_RX_CLK];
            if (rx_loss) begin
                // both rails inactive together
                rx_data_pos_n_o <= 1'b1;
                rx_data_neg_n_o <= 1'b1;
            end else if (buf_valid && rx_ready_i) begin
                rx_data_pos_n_o <= !buf_data[0];
                rx_data_neg_n_o <= !buf_data[1];
            end
        end
    end

    // ------------------------------------------------------------ transmit path
    // one mark per transmit clock edge; remote loop takes the recovered bits
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_line_a_o <= 1'b0;
            tx_line_b_o <= 1'b0;
        end else if (tx_edge) begin
            if (remote_loop_o) begin
                tx_line_a_o <= rx_mark_a;
                tx_line_b_o <= rx_mark_b;
            end else begin
                tx_line_a_o <= !pins_sync[`PIN_TXD_P];
                tx_line_b_o <= !pins_sync[`PIN_TXD_N];
            end
        end
    end

    // transmit loss: count transmit clock cycles with no sensed mark
    reg [`LOS_CNT_W-1:0] tx_los_cnt; // cycles without a mark
    reg tx_loss; // transmit loss in force
    wire tx_mark_seen; // driver sense shows a mark
    assign tx_mark_seen = pins_sync[`PIN_SENSE_A] || pins_sync[`PIN_SENSE_B];
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_los_cnt <= {`LOS_CNT_W{1'b0}};
            tx_loss <= 1'b0;
        end else if (tx_mark_seen) begin
            tx_los_cnt <= {`LOS_CNT_W{1'b0}};
            tx_loss <= 1'b0;
        end else if (tx_edge && !tx_loss) begin
            tx_los_cnt <= tx_los_cnt + {{(`LOS_CNT_W-1){1'b0}}, 1'b1};
            if (tx_los_cnt == (`TX_LOS_CYC - 1)) begin
                tx_loss <= 1'b1;
            end
        end
    end

    // oscillator pins carry the indications only with the mode pin low
    assign rx_sig_loss_n_o = pins_sync[`PIN_MODE] ? 1'b1 : !rx_loss;
    assign tx_sig_loss_n_o = pins_sync[`PIN_MODE] ? 1'b1 : !tx_loss;

endmodule

// ===== bench/line_ctrl_assertions.sv
`timescale 1ns/100ps
// pin level checker for the line control block
module line_ctrl_assertions (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // link clocks and level inputs
    input wire rx_clk_i,
    input wire tx_clk_i,
    input wire rx_level_low_i,
    input wire tx_sense_a_i,
    input wire tx_sense_b_i,
    // control port
    input wire local_loop_sel_i,
    input wire remote_loop_sel_i,
    input wire ctrl_latch_sel_n_i,
    input wire mode_i,
    // watched outputs
    input wire rx_data_pos_n_o,
    input wire rx_data_neg_n_o,
    input wire rx_sig_loss_n_o,
    input wire tx_sig_loss_n_o,
    input wire t1_mode_o,
    input wire [2:0] line_len_o,
    input wire local_loop_o,
    input wire remote_loop_o,
    input wire reset_done_o
);
    reg [1:0] rx_s; // receive clock edge finder
    reg [1:0] tx_s; // transmit clock edge finder
    reg [5:0] rx_low; // receive edges seen with low level
    reg [5:0] tx_quiet; // transmit edges seen without a mark
    reg [8:0] run; // cycles with both selects high
    reg [8:0] last_run; // length of the last combined pulse
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // counts link edges and pulse lengths in the system clock
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_s <= 2'h0;
            tx_s <= 2'h0;
            rx_low <= 6'h00;
            tx_quiet <= 6'h00;
            run <= 9'h000;
            last_run <= 9'h000;
        end else begin
            rx_s <= {rx_s[0], rx_clk_i};
            tx_s <= {tx_s[0], tx_clk_i};
            // level back to normal restarts the count
            if (!rx_level_low_i)
                rx_low <= 6'h00;
            else if (rx_s == 2'h1 && rx_low != 6'h3F)
                rx_low <= rx_low + 6'h01;
            // any mark on the driver restarts the count
            if (tx_sense_a_i || tx_sense_b_i)
                tx_quiet <= 6'h00;
            else if (tx_s == 2'h1 && tx_quiet != 6'h3F)
                tx_quiet <= tx_quiet + 6'h01;
            if (local_loop_sel_i && remote_loop_sel_i)
                run <= run + {8'h00, run != 9'h1FF};
            else
                run <= 9'h000;
            // keep the width of a pulse that just ended
            if (!(local_loop_sel_i && remote_loop_sel_i) && run != 9'h000)
                last_run <= run;
        end
    end
    a_loss_rails: assert property ((!rx_sig_loss_n_o)[*3] |-> rx_data_pos_n_o && rx_data_neg_n_o)
        else $error("receive rails not idle during loss");
    // a mode pin falling also lowers the loss pins, so only falls with mode held low count
    a_rx_loss_count: assert property ($fell(rx_sig_loss_n_o) && !$past(mode_i, 2)
        && !$past(mode_i, 3) |-> rx_low >= 6'h20)
        else $error("receive loss shown too early");
    a_tx_loss_count: assert property ($fell(tx_sig_loss_n_o) && !$past(mode_i, 2)
        && !$past(mode_i, 3) |-> tx_quiet >= 6'h20)
        else $error("transmit loss shown too early");
    a_mode_hides: assert property (mode_i[*4] |-> rx_sig_loss_n_o && tx_sig_loss_n_o)
        else $error("loss shown with mode high");
    a_loss_release: assert property ((!rx_level_low_i)[*4] |-> rx_sig_loss_n_o)
        else $error("receive loss kept after signal returned");
    a_pulse_width: assert property (reset_done_o |-> last_run >= 9'h0C8)
        else $error("reset taken from a short pulse");
    a_mode_load: assert property (reset_done_o |=> t1_mode_o == (line_len_o != 3'h0))
        else $error("mode does not match length code");
    a_cfg_hold: assert property ($changed({t1_mode_o, line_len_o}) |-> reset_done_o || $past(reset_done_o))
        else $error("configuration changed without reset");
    a_latch_hold: assert property (ctrl_latch_sel_n_i[*6] |-> $stable({local_loop_o, remote_loop_o}))
        else $error("loops changed while latched");
    c_reset: cover property (reset_done_o && line_len_o == 3'h7);
    c_rx_loss: cover property ($fell(rx_sig_loss_n_o));
    c_tx_loss: cover property ($fell(tx_sig_loss_n_o));
endmodule

// ===== bench/framer_model.sv
`timescale 1ns/100ps
// framer taking receive words, able to stall
module framer_model (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // receive handshake
    input wire valid_i,
    output reg ready_o,
    // test control and status
    input wire stall_i,
    output reg [15:0] pops_o
);
    initial ready_o = 1'h0;
    // ready moves only at the falling edge
    always @(negedge clk_i)
        ready_o <= !stall_i;
    // counts words taken; the rails themselves are not read here
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            pops_o <= 16'h0000;
        else if (valid_i && ready_o)
            pops_o <= pops_o + 16'h0001;
    end
endmodule

// ===== bench/testbench.sv
`timescale 1ns/100ps
`include "line_ctrl_defines.vh"
module testbench;
    reg clk = 1'h0, rst_n = 1'h0, rx_clk = 1'h0, tx_clk = 1'h0;
    reg rxa = 1'h0, rxb = 1'h0, lvl = 1'h0, tp = 1'h1, tn = 1'h1;
    reg txp = 1'h1, txn = 1'h1, sa = 1'h0, sb = 1'h0, mode = 1'h1;
    reg loc = 1'h0, rem = 1'h0, sel_n = 1'h0, stall = 1'h0, sense_en = 1'h1;
    reg [2:0] len = 3'h0;
    reg seen;
    reg [11:0] rows [0:5]; // loc rem rxa rxb tp tn txp txn | txa txb rpn rnn
    wire rpn, rnn, rval, rrdy, txa, txb, rx_sig_loss_n, tx_sig_loss_n, t1, ll, rl, done, rclk;
    wire [2:0] llen;
    wire [15:0] pops;
    integer errors = 0, n_compared = 0, i, k;
    // system clock and the two link clocks
    always #2.5 clk = ~clk;
    always #40 rx_clk = ~rx_clk;
    initial #20 forever #40 tx_clk = ~tx_clk;
    // driver sense follows the line marks while enabled
    always @(negedge clk) begin
        sa <= sense_en & txa;
        sb <= sense_en & txb;
    end
    line_interface_ctrl line_interface_ctrl_i (.clk_i(clk), .rst_n_i(rst_n),
        .rx_clk_i(rx_clk), .tx_clk_i(tx_clk), .rx_line_a_i(rxa), .rx_line_b_i(rxb),
        .rx_level_low_i(lvl), .test_in_pos_i(tp), .test_in_neg_i(tn),
        .tx_data_pos_n_i(txp), .tx_data_neg_n_i(txn), .tx_sense_a_i(sa),
        .tx_sense_b_i(sb), .local_loop_sel_i(loc), .remote_loop_sel_i(rem),
        .line_len_sel0_i(len[0]), .line_len_sel1_i(len[1]), .line_len_sel2_i(len[2]),
        .ctrl_latch_sel_n_i(sel_n), .mode_i(mode), .rx_data_pos_n_o(rpn),
        .rx_data_neg_n_o(rnn), .recovered_clk_o(rclk), .rx_valid_o(rval),
        .rx_ready_i(rrdy), .tx_line_a_o(txa), .tx_line_b_o(txb),
        .rx_sig_loss_n_o(rx_sig_loss_n), .tx_sig_loss_n_o(tx_sig_loss_n), .t1_mode_o(t1),
        .line_len_o(llen), .local_loop_o(ll), .remote_loop_o(rl), .reset_done_o(done));
    framer_model framer_model_i (.clk_i(clk), .rst_n_i(rst_n), .valid_i(rval),
        .ready_o(rrdy), .stall_i(stall), .pops_o(pops));
    // compares one value and counts the outcome
    task check(input [15:0] got, input [15:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clk);
    endtask
    // combined select pulse of n cycles, then a bounded wait for the answer
    task pulse(input [2:0] code, input integer n, input exp);
        begin
            len = code;
            loc = 1'h1;
            rem = 1'h1;
            cyc(n);
            loc = 1'h0;
            rem = 1'h0;
            seen = 1'h0;
            for (k = 0; k < 12; k = k + 1) begin
                @(negedge clk);
                seen = seen | done;
            end
            check(seen, exp);
            if (exp)
                check({t1, llen}, {code != 3'h0, code});
        end
    endtask
    task print_verdict;
        begin
            $display("compared %0d, mismatches %0d", n_compared, errors);
            if (errors == 0 && n_compared > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // cut a hang short
    initial begin
        #100000;
        errors = errors + 1;
        print_verdict;
    end
    initial begin
        rows[0] = 12'h2D9;
        rows[1] = 12'h1E6;
        rows[2] = 12'h965;
        rows[3] = 12'h89A;
        rows[4] = 12'h6F9;
        rows[5] = 12'h5C6;
        cyc(3);
        rst_n = 1'h1;
        cyc(4);
        check({t1, llen}, 4'h0);
        // normal, local and remote paths
        for (i = 0; i < 6; i = i + 1) begin
            {loc, rem, rxa, rxb, tp, tn, txp, txn} = rows[i][11:4];
            cyc(160);
            check({ll, rl}, rows[i][11:10]);
            check({txa, txb}, rows[i][3:2]);
            check({rpn, rnn}, rows[i][1:0]);
            // recovered clock follows the line clock a few cycles late
            @(posedge rx_clk);
            cyc(4);
            check(rclk, 1'h1);
            @(negedge rx_clk);
            cyc(4);
            check(rclk, 1'h0);
            $display("row %0d done", i);
        end
        // select line high freezes the loops
        loc = 1'h1;
        rem = 1'h0;
        cyc(6);
        sel_n = 1'h1;
        cyc(4);
        loc = 1'h0;
        cyc(10);
        check({ll, rl}, 2'h2);
        sel_n = 1'h0;
        cyc(6);
        check({ll, rl}, 2'h0);
        $display("latch test done");
        // every length code, then a short pulse that must be ignored
        for (i = 0; i < 8; i = i + 1)
            pulse(i[2:0], `RST_MIN_CYC + 2, 1'h1);
        pulse(3'h5, `RST_MIN_CYC - 2, 1'h0);
        check({t1, llen}, 4'hF);
        $display("reset test done");
        // receive loss
        mode = 1'h0;
        lvl = 1'h1;
        cyc(16 * (`RX_LOS_BITS - 4));
        check(rx_sig_loss_n, 1'h1);
        cyc(16 * 8);
        check({rx_sig_loss_n, rpn, rnn}, 3'h3);
        mode = 1'h1;
        cyc(6);
        check(rx_sig_loss_n, 1'h1);
        mode = 1'h0;
        lvl = 1'h0;
        cyc(6);
        check(rx_sig_loss_n, 1'h1);
        // transmit loss
        sense_en = 1'h0;
        cyc(16 * (`TX_LOS_CYC - 4));
        check(tx_sig_loss_n, 1'h1);
        cyc(16 * 8);
        check(tx_sig_loss_n, 1'h0);
        sense_en = 1'h1;
        cyc(40);
        check(tx_sig_loss_n, 1'h1);
        $display("loss test done");
        // framer stall takes nothing and leaves a word waiting, then resumes
        stall = 1'h1;
        cyc(2);
        k = pops;
        cyc(160);
        check(rval, 1'h1);
        check(pops, k[15:0]);
        stall = 1'h0;
        cyc(40);
        check(pops > k[15:0], 1'h1);
        $display("stall test done");
        // power-on reset in mid-run brings back cept
        rst_n = 1'h0;
        cyc(2);
        check({t1, llen, rpn, rnn, rx_sig_loss_n, tx_sig_loss_n, txa, txb, done}, 11'h078);
        rst_n = 1'h1;
        cyc(2);
        $display("mid-run reset test done");
        print_verdict;
    end
endmodule
bind line_interface_ctrl line_ctrl_assertions line_ctrl_assertions_i (.clk_i, .rst_n_i,
    .rx_clk_i, .tx_clk_i, .rx_level_low_i, .tx_sense_a_i, .tx_sense_b_i,
    .local_loop_sel_i, .remote_loop_sel_i, .ctrl_latch_sel_n_i, .mode_i,
    .rx_data_pos_n_o, .rx_data_neg_n_o, .rx_sig_loss_n_o, .tx_sig_loss_n_o,
    .t1_mode_o, .line_len_o, .local_loop_o, .remote_loop_o, .reset_done_o);
